// ---- pkg/pblp_pkg.sv ----
// Constants, types and helpers shared by the parallel bitstream load port.
package pblp_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LENGTH = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] LENGTH_RESET = 32'h0000_0001;

    // Bus width codes of the control register.
    localparam logic [1:0] BW_8 = 2'h0;
    localparam logic [1:0] BW_16 = 2'h1;
    localparam logic [31:0] MASK_8 = 32'h0000_00FF;
    localparam logic [31:0] MASK_16 = 32'h0000_FFFF;
    localparam logic [31:0] MASK_32 = 32'hFFFF_FFFF;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 20;
    localparam int T_REQ_TO_LOW_NS = 600;
    localparam int T_STATUS_MIN_US = 268;
    localparam int T_STATUS_MAX_US = 1506;
    localparam int T_INIT_MIN_US = 175;
    localparam int T_INIT_MAX_US = 437;
    localparam int USER_INIT_PERIODS = 8576;
    localparam int CU_LOAD_PERIODS = 4;
    localparam int LOAD_CLK_MAX_PERIOD_NS = 10;
    localparam int REQ_TO_LOW_CYC = T_REQ_TO_LOW_NS / CLK_NS;
    localparam int STATUS_MIN_CYC = (T_STATUS_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int INIT_MIN_CYC = (T_INIT_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int CU_CYC =
        (CU_LOAD_PERIODS * LOAD_CLK_MAX_PERIOD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 17;
    // Synchroniser reset levels {load clock, request, status, user clock}.
    localparam logic [3:0] PIN_SYNC_RST = 4'h4;

    // Status register bit positions.
    localparam int ST_RATIO_LSB = 0;
    localparam int ST_BUSY_BIT = 4;
    localparam int ST_LOADING_BIT = 5;
    localparam int ST_DONE_BIT = 6;
    localparam int ST_USER_BIT = 7;

    // Clock-to-word ratios.
    localparam logic [3:0] RATIO_1 = 4'h1;
    localparam logic [3:0] RATIO_2 = 4'h2;
    localparam logic [3:0] RATIO_4 = 4'h4;
    localparam logic [3:0] RATIO_8 = 4'h8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic init_done_en;
        logic user_clk_opt;
        logic encrypt_en;
        logic decomp_en;
        logic [1:0] bus_width;
    } pblp_ctrl_t;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } pblp_word_t;

    typedef enum logic [3:0] {
        ST_POR, ST_CFG_LOW, ST_STATUS_LOW, ST_EXT_HOLD, ST_LOAD,
        ST_TAIL, ST_DONE_WAIT, ST_INIT_WAIT, ST_INIT, ST_USER
    } pblp_state_t;

    function automatic logic [3:0] pblp_ratio(input pblp_ctrl_t c);
        logic [3:0] r;
        r = RATIO_1;
        if (c.bus_width == BW_8) begin
            r = c.decomp_en ? RATIO_2 : RATIO_1;
        end else if (c.bus_width == BW_16) begin
            r = c.decomp_en ? RATIO_4 : (c.encrypt_en ? RATIO_2 : RATIO_1);
        end else begin
            r = c.decomp_en ? RATIO_8 : (c.encrypt_en ? RATIO_4 : RATIO_1);
        end
        return r;
    endfunction

endpackage

// ---- hw/pblp_loader.sv ----
// Parallel bitstream load port with its register slave and status pins.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

// ------------------------------------------------------------
// Two-stage synchroniser
// ------------------------------------------------------------
module pblp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic ref_clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic [W-1:0] d, // asynchronous input
    output logic [W-1:0] q // synchronised output
);
    logic [W-1:0] meta_ff;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= RST;
            q <= RST;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule

// Behaviour
// R1: 8-bit bus: ratio 1 without decompression, 2 with it.
// R2: 16-bit bus: ratio 1 plain, 2 encryption only, 4 with decompression.
// R3: 32-bit bus: ratio 1 plain, 4 encryption only, 8 with decompression.
// R4: Host clocks load clock at r times word rate, holding each word r cycles.
// R5: Spare load-clock cycles of each word are spent decrypting and decompressing.
// R6: Host keeps clocking r-1 cycles after the last word before stopping.
// R7: 8-bit mode uses data 7..0, 16-bit mode uses data 15..0.
// R8: User mode has request, status, done high; request low restarts configuration.
// R9: Status line held low for the power-on delay after power-up.
// R10: Done flag stays low from power-up through loading until completion.
// R11: Host sends whole bitstream; done released only after all words arrive.
// R12: Two load-clock falling edges after done start initialization.
// R13: Load clock ignored after configuration; host keeps it driven.
// R14: Init-done output driven low once its enabling option is loaded.
// R15: Data lines become user I/O after configuration.
// R16: Done and status go low within 600 ns of request falling.
// R17: Host holds request low at least 2 us.
// R18: Status held low between 268 and 1506 us unless extended outside.
// R19: Status released within 1506 us of request rising unless held outside.
// R20: Host waits 2 us after status rise, or 1506 us after request rise.
// R21: Internal oscillator: user mode 175 to 437 us after done rises.
// R22: User clock option: wait 4 load periods, then 8576 user-clock periods.
// R23: Host may pause load clock low, presenting data before its next rise.
// R24: A word is captured on a rising edge, the next after r cycles.
// R25: Load clock and data are ignored until status is released.
module pblp_loader
    import pblp_pkg::*;
#(
    parameter int STATUS_CYC = STATUS_MIN_CYC,
    parameter int INIT_CYC = INIT_MIN_CYC,
    parameter int USER_PERIODS = USER_INIT_PERIODS
) (
    input wire logic ref_clk, // 50 MHz system clock
    input wire logic resetn, // async reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic load_clock, // host load clock pin
    input wire logic [31:0] load_data, // data pins
    input wire logic reconfig_request_n, // reconfiguration request pin
    input wire logic config_status_n_i, // status line level
    output logic config_status_n_o, // status line drive value
    output logic config_status_n_oe, // status line drive enable
    input wire logic load_done_flag_i, // done line level
    output logic load_done_flag_o, // done line drive value
    output logic load_done_flag_oe, // done line drive enable
    input wire logic user_init_clock, // optional initialization clock
    output logic init_done_n, // initialization done output
    output logic user_io_en, // data pins handed to user logic
    output pblp_word_t word_out // captured configuration word
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_s;
    logic [31:0] data_s;
    // The request line idles high, so its flops reset high and no false request follows reset.
    pblp_sync #(.W(4), .RST(PIN_SYNC_RST)) u_sync_pins (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .d({load_clock, reconfig_request_n, config_status_n_i, user_init_clock}),
        .q(pin_s)
    );
    pblp_sync #(.W(32)) u_sync_data (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .d(load_data),
        .q(data_s)
    );

    wire lclk_s = pin_s[3];
    wire req_n_s = pin_s[2];
    wire stat_s = pin_s[1];
    wire uclk_s = pin_s[0];

    logic lclk_d_ff;
    logic uclk_d_ff;
    logic req_d_ff;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lclk_d_ff <= 1'b0;
            uclk_d_ff <= 1'b0;
            req_d_ff <= 1'b1;
        end else begin
            lclk_d_ff <= lclk_s;
            uclk_d_ff <= uclk_s;
            req_d_ff <= req_n_s;
        end
    end

    wire lclk_rise = lclk_s & ~lclk_d_ff;
    wire lclk_fall = ~lclk_s & lclk_d_ff;
    wire uclk_rise = uclk_s & ~uclk_d_ff;
    wire req_fall = req_d_ff & ~req_n_s;

    // ------------------------------------------------------------
    // Registers and bus slave
    // ------------------------------------------------------------
    pblp_ctrl_t ctrl_ff;
    logic [31:0] len_ff;
    logic [31:0] words_ff;
    logic [ADDR_W-1:0] waddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    pblp_state_t state_ff;
    pblp_state_t nxt_state;
    logic [3:0] phase_ff;

    wire [3:0] ratio = pblp_ratio(ctrl_ff); // R1 R2 R3
    wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire wr_ctrl = wr_go && (waddr_ff == OFS_CTRL);
    wire wr_len = wr_go && (waddr_ff == OFS_LENGTH);
    wire wr_hit = wr_ctrl || wr_len;
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire in_load = (state_ff == ST_LOAD) || (state_ff == ST_TAIL);
    wire cfg_done = (state_ff == ST_DONE_WAIT) || (state_ff == ST_INIT_WAIT)
                    || (state_ff == ST_INIT) || (state_ff == ST_USER);

    logic [31:0] status_word;
    always_comb begin
        status_word = '0;
        status_word[ST_RATIO_LSB +: 4] = ratio;
        status_word[ST_BUSY_BIT] = (phase_ff != 4'h0);
        status_word[ST_LOADING_BIT] = in_load;
        status_word[ST_DONE_BIT] = cfg_done;
        status_word[ST_USER_BIT] = (state_ff == ST_USER);
    end

    wire rd_ctrl = (s_axi_araddr == OFS_CTRL);
    wire rd_len = (s_axi_araddr == OFS_LENGTH);
    wire rd_stat = (s_axi_araddr == OFS_STATUS);
    wire rd_cnt = (s_axi_araddr == OFS_COUNT);
    wire rd_hit = rd_ctrl || rd_len || rd_stat || rd_cnt;
    wire [31:0] rd_mux = rd_ctrl ? {{(32 - $bits(pblp_ctrl_t)){1'b0}}, ctrl_ff}
                       : rd_len ? len_ff
                       : rd_stat ? status_word
                       : rd_cnt ? words_ff : 32'h0000_0000;

    // Byte lanes mask every byte of writes to both the control and length registers.
    wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                         {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            waddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                waddr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= '0;
            len_ff <= LENGTH_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= pblp_ctrl_t'((wdata_ff & wmask) | (32'(ctrl_ff) & ~wmask));
            end
            if (wr_len) begin
                len_ff <= (wdata_ff & wmask) | (len_ff & ~wmask);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Configuration sequence
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cnt_ff;
    logic [1:0] fall_cnt_ff;
    logic opt_seen_ff;

    wire phase_last = (phase_ff == ratio - 4'h1);
    wire capture = (state_ff == ST_LOAD) && lclk_rise && (phase_ff == 4'h0); // R24 R25
    wire last_word = capture && ((words_ff + 32'h1) >= len_ff); // R11
    wire status_cnt_end = (cnt_ff >= CNT_W'(STATUS_CYC - 1));
    wire init_end = ctrl_ff.user_clk_opt
                    ? (uclk_rise && (cnt_ff == CNT_W'(USER_PERIODS - 1)))
                    : (cnt_ff == CNT_W'(INIT_CYC - 1));

    always_comb begin
        nxt_state = state_ff;
        if (!req_n_s) begin
            nxt_state = ST_CFG_LOW; // R8
        end else begin
            case (state_ff)
                ST_POR: if (status_cnt_end) nxt_state = ST_EXT_HOLD; // R9
                ST_CFG_LOW: nxt_state = ST_STATUS_LOW;
                ST_STATUS_LOW: if (status_cnt_end) nxt_state = ST_EXT_HOLD; // R18 R19
                ST_EXT_HOLD: if (stat_s) nxt_state = ST_LOAD; // R25
                ST_LOAD: begin
                    if (last_word) begin
                        nxt_state = (ratio == RATIO_1) ? ST_DONE_WAIT : ST_TAIL;
                    end
                end
                ST_TAIL: if (lclk_rise && phase_last) nxt_state = ST_DONE_WAIT; // R6
                ST_DONE_WAIT: begin
                    if (lclk_fall && fall_cnt_ff == 2'h1) begin // R12
                        nxt_state = ctrl_ff.user_clk_opt ? ST_INIT_WAIT : ST_INIT;
                    end
                end
                ST_INIT_WAIT: if (cnt_ff >= CNT_W'(CU_CYC - 1)) nxt_state = ST_INIT; // R22
                ST_INIT: if (init_end) nxt_state = ST_USER; // R21 R22
                ST_USER: nxt_state = ST_USER; // R13
                default: nxt_state = ST_POR;
            endcase
        end
    end

    // The counter keeps running from the request edge into the status hold.
    wire cnt_keep = (state_ff == ST_CFG_LOW) && (nxt_state == ST_STATUS_LOW);
    wire cnt_clr = (nxt_state != state_ff) && !cnt_keep;
    wire cnt_sat = (cnt_ff == {CNT_W{1'b1}});
    wire cnt_inc = !cnt_sat && ((state_ff != ST_INIT) || !ctrl_ff.user_clk_opt || uclk_rise);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_POR;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= cnt_clr ? '0 : (cnt_inc ? cnt_ff + 1'b1 : cnt_ff);
        end
    end

    // Spare phases of each word period are the decrypt and inflate slots.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            phase_ff <= 4'h0;
        end else if (!in_load) begin
            phase_ff <= 4'h0;
        end else if (lclk_rise) begin
            phase_ff <= phase_last ? 4'h0 : phase_ff + 4'h1; // R5 R24
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            words_ff <= '0;
            fall_cnt_ff <= '0;
            opt_seen_ff <= 1'b0;
        end else begin
            if (state_ff == ST_CFG_LOW) begin
                words_ff <= '0;
                opt_seen_ff <= 1'b0;
            end else if (capture) begin
                words_ff <= words_ff + 32'h1;
                opt_seen_ff <= opt_seen_ff | ctrl_ff.init_done_en; // R14
            end
            if (state_ff != ST_DONE_WAIT) begin
                fall_cnt_ff <= '0;
            end else if (lclk_fall) begin
                fall_cnt_ff <= fall_cnt_ff + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Pins and word output
    // ------------------------------------------------------------
    wire [31:0] width_mask = (ctrl_ff.bus_width == BW_8) ? MASK_8
                           : (ctrl_ff.bus_width == BW_16) ? MASK_16 : MASK_32;
    wire nxt_status_oe = (nxt_state == ST_POR) || (nxt_state == ST_CFG_LOW)
                         || (nxt_state == ST_STATUS_LOW);
    wire nxt_done_oe = !((nxt_state == ST_DONE_WAIT) || (nxt_state == ST_INIT_WAIT)
                       || (nxt_state == ST_INIT) || (nxt_state == ST_USER));

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            config_status_n_oe <= 1'b1;
            config_status_n_o <= 1'b0;
            load_done_flag_oe <= 1'b1;
            load_done_flag_o <= 1'b0;
            init_done_n <= 1'b1;
            user_io_en <= 1'b0;
            word_out <= '0;
        end else begin
            config_status_n_oe <= nxt_status_oe; // R9 R16 R18
            config_status_n_o <= 1'b0;
            load_done_flag_oe <= nxt_done_oe; // R10 R11 R16
            load_done_flag_o <= 1'b0;
            init_done_n <= !(opt_seen_ff && (nxt_state != ST_USER)); // R14
            user_io_en <= (nxt_state == ST_USER); // R15
            word_out.valid <= capture;
            word_out.data <= capture ? (data_s & width_mask) : word_out.data; // R7
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [CNT_W-1:0] low_cnt_ff;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            low_cnt_ff <= '0;
        end else if (!config_status_n_oe) begin
            low_cnt_ff <= '0;
        end else if (low_cnt_ff != {CNT_W{1'b1}}) begin
            low_cnt_ff <= low_cnt_ff + 1'b1;
        end
    end

    sequence s_both_low;
        config_status_n_oe && load_done_flag_oe;
    endsequence

    a_req_pulls_low: assert property (@(posedge ref_clk) disable iff (!resetn) // R16
        req_fall |-> ##[0:2] s_both_low)
        else $error("status or done not driven low after request");
    a_ratio_eight: assert property (@(posedge ref_clk) disable iff (!resetn) // R1
        (ctrl_ff.bus_width == BW_8) |-> (ratio == (ctrl_ff.decomp_en ? RATIO_2 : RATIO_1)))
        else $error("wrong ratio on 8-bit bus");
    a_ratio_sixteen: assert property (@(posedge ref_clk) disable iff (!resetn) // R2
        (ctrl_ff.bus_width == BW_16 && !ctrl_ff.decomp_en && ctrl_ff.encrypt_en)
        |-> (ratio == RATIO_2))
        else $error("wrong ratio on 16-bit bus");
    a_ratio_wide: assert property (@(posedge ref_clk) disable iff (!resetn) // R3
        (ctrl_ff.bus_width != BW_8 && ctrl_ff.bus_width != BW_16 && ctrl_ff.decomp_en)
        |-> (ratio == RATIO_8))
        else $error("wrong ratio on 32-bit bus");
    a_done_held_low: assert property (@(posedge ref_clk) disable iff (!resetn) // R10
        in_load |-> load_done_flag_oe)
        else $error("done released while loading");
    a_status_min_low: assert property (@(posedge ref_clk) disable iff (!resetn) // R18
        $fell(config_status_n_oe) |-> (low_cnt_ff >= CNT_W'(STATUS_CYC - 1)))
        else $error("status released too early");
    a_word_spacing: assert property (@(posedge ref_clk) disable iff (!resetn) // R24
        (word_out.valid && ratio != RATIO_1) |=> !word_out.valid [*3])
        else $error("words captured too close together");
    a_narrow_mask: assert property (@(posedge ref_clk) disable iff (!resetn) // R7
        (word_out.valid && ctrl_ff.bus_width == BW_8) |-> (word_out.data[31:8] == '0))
        else $error("upper data lanes used in 8-bit mode");
    a_user_quiet: assert property (@(posedge ref_clk) disable iff (!resetn) // R13
        (state_ff == ST_USER) |-> (!word_out.valid && user_io_en && !load_done_flag_oe))
        else $error("load activity in user mode");
    a_ignore_early: assert property (@(posedge ref_clk) disable iff (!resetn) // R25
        config_status_n_oe |=> !word_out.valid)
        else $error("word taken before status release");

endmodule

// ---- verif/pblp_host.sv ----
// Host model that drives the load clock, data pins and request line.
`timescale 1ns/1ps
module pblp_host (
    output logic load_clock, // load clock pin
    output logic [31:0] load_data, // data pins
    output logic reconfig_request_n, // request line
    input wire logic status_n // resolved status line
);
    initial begin
        load_clock = 1'b0;
        load_data = 32'h0;
        reconfig_request_n = 1'b1;
    end
    task automatic start();
        reconfig_request_n <= 1'b0;
        #2100 reconfig_request_n <= 1'b1;
        wait (status_n === 1'b1);
        #2100;
    endtask
    // The clock rests low between calls and is never left floating.
    task automatic tick(input int n);
        repeat (n) begin
            #80 load_clock <= 1'b1;
            #80 load_clock <= 1'b0;
        end
    endtask
    task automatic send(input logic [31:0] w, input int r);
        load_data <= w;
        tick(r);
        load_data <= ~w;
    endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the parallel bitstream load port.
`timescale 1ns/1ps
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
module tb;
    import pblp_pkg::*;
    localparam logic [47:0] RTAB = 48'h8841_4421_2211;
    logic ref_clk = 1'b0, resetn = 1'b0, user_init_clock = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, load_data, last;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic load_clock, reconfig_request_n, config_status_n_o, config_status_n_oe;
    logic load_done_flag_o, load_done_flag_oe, init_done_n, user_io_en;
    pblp_word_t word_out;
    int error_cnt = 0, checks = 0;
    // Both lines are open drain with pull-ups.
    wire config_status_n_i = config_status_n_oe ? config_status_n_o : 1'b1;
    wire load_done_flag_i = load_done_flag_oe ? load_done_flag_o : 1'b1;
    pblp_loader #(.STATUS_CYC(40), .INIT_CYC(30), .USER_PERIODS(5)) i_pblp_loader (.*);
    pblp_host i_pblp_host (.load_clock(load_clock), .load_data(load_data),
        .reconfig_request_n(reconfig_request_n), .status_n(config_status_n_i));
    initial forever #10 ref_clk = ~ref_clk;
    initial forever #37 user_init_clock = ~user_init_clock;
    always @(posedge ref_clk) if (word_out.valid === 1'b1) last <= word_out.data;
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic run(input int i);
        logic [31:0] c, w, m, d;
        logic [1:0] rs;
        logic [3:0] r;
        c = {26'h0, 1'(i >= 6), 1'(i == 11), i[0], i[1], i[3:2]};
        r = RTAB[4*i +: 4];
        w = 32'hA5C3_9E71 ^ 32'(i);
        m = (i < 4) ? MASK_8 : (i < 8) ? MASK_16 : MASK_32;
        wr(OFS_CTRL, c, rs);
        wr(OFS_LENGTH, 32'h2, rs);
        fork
            i_pblp_host.start();
            begin
                repeat (30) @(posedge ref_clk);
                `CHK({config_status_n_i, load_done_flag_i}, 2'b00, "req low")
            end
        join
        rd(OFS_STATUS, d, rs);
        `CHK(d[3:0], r, "ratio")
        i_pblp_host.send(w, int'(r));
        repeat (8) @(posedge ref_clk);
        `CHK(last, w & m, "word")
        `CHK(load_done_flag_i, 1'b0, "done early")
        if (i >= 6) `CHK(init_done_n, 1'b0, "init low")
        // The last word's own hold supplies the r-1 trailing clocks.
        i_pblp_host.send(~w, int'(r));
        while (load_done_flag_i !== 1'b1) @(posedge ref_clk);
        rd(OFS_COUNT, d, rs);
        `CHK(d, 32'h2, "count")
        repeat (40) @(posedge ref_clk);
        `CHK(user_io_en, 1'b0, "init before falls")
        i_pblp_host.tick(2);
        while (user_io_en !== 1'b1) @(posedge ref_clk);
        `CHK({config_status_n_i, load_done_flag_i, init_done_n}, 3'b111, "user")
        $display("test %0d done", i);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #400_000;
        error_cnt++;
        close_out();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] rs;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK({config_status_n_i, load_done_flag_i}, 2'b00, "por")
        rd(OFS_LENGTH, d, rs);
        `CHK(d, LENGTH_RESET, "length reset")
        wr(OFS_STATUS, 32'h0, rs);
        `CHK(rs, RESP_SLVERR, "ro write")
        rd(8'h40, d, rs);
        `CHK(rs, RESP_SLVERR, "unmapped")
        $display("test regs done");
        for (int i = 0; i < 12; i++) run(i);
        close_out();
    end
endmodule
